// *** core/charger_status_reg_target.sv ***
module charger_status_reg_target
    import chg_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire charger_status_type status,
    input wire logic both_supplies,
    input wire logic on_wrong_supply,
    input wire logic bus_supply_present,
    output charger_control_type control
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_RX = 5'b00100,
        ST_TX = 5'b01000,
        ST_ACK = 5'b10000
    } bus_state_type;

    logic rst_a_r;
    logic rst_n;
    logic scl;
    logic scl_rise;
    logic scl_fall;
    logic sda;
    logic sda_rise;
    logic sda_fall;
    bus_state_type state_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] reg_ptr_r;
    logic ptr_loaded_r;
    logic reading_r;
    logic ack_drive_r;
    logic addr_ok_r;
    logic supply_sel_r;
    logic lockout_r;
    logic cell_absent_r;
    logic [2:0] fault_r;
    logic kick_r;
    logic restart_r;
    logic [7:0] read_byte;
    logic fault_read;
    logic start_cond;
    logic stop_cond;

    // Reset release passes two flip-flops.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_a_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_a_r <= 1'b1;
            rst_n <= rst_a_r;
        end
    end

    pin_sync u_scl (
        .mclk(mclk),
        .rst_n(rst_n),
        .pin(scl_in),
        .level(scl),
        .rise(scl_rise),
        .fall(scl_fall)
    );

    pin_sync u_sda (
        .mclk(mclk),
        .rst_n(rst_n),
        .pin(sda_in),
        .level(sda),
        .rise(sda_rise),
        .fall(sda_fall)
    );

    // Start and stop are SDA edges while SCL stays high.
    assign start_cond = sda_fall && scl && !scl_fall;
    assign stop_cond = sda_rise && scl && !scl_fall;

    // Read data: unmapped addresses return all ones, kick bit reads zero.
    always_comb begin
        case (reg_ptr_r)
            REG_STATE_FAULT_CONTROL: read_byte = {1'b0, status.charge_state,
                supply_sel_r, fault_r};
            REG_SUPPLY_BATTERY_STATE: read_byte = {status.primary_input_state,
                status.bus_input_state, lockout_r,
                status.cell_state, cell_absent_r};
            default: read_byte = UNMAPPED_READ;
        endcase
    end

    // Serial state machine, bit counting and shifting on SCL edges.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            reading_r <= 1'b0;
            addr_ok_r <= 1'b0;
        end else if (start_cond) begin
            state_r <= ST_ADDR;
            bit_cnt_r <= 4'h0;
        end else if (stop_cond) begin
            state_r <= ST_IDLE;
        end else if (scl_rise) begin
            case (state_r)
                ST_ADDR, ST_RX: begin
                    shift_r <= {shift_r[6:0], sda};
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                end
                ST_TX: bit_cnt_r <= bit_cnt_r + 4'h1;
                ST_ACK: if (reading_r && !ack_drive_r && sda) begin
                    state_r <= ST_IDLE; // Host declined further data.
                end
                default: state_r <= state_r;
            endcase
        end else if (scl_fall) begin
            case (state_r)
                ST_ADDR: if (bit_cnt_r == 4'h8) begin
                    addr_ok_r <= (shift_r[7:1] == TARGET_ADDR);
                    reading_r <= shift_r[0];
                    state_r <= (shift_r[7:1] == TARGET_ADDR) ? ST_ACK : ST_IDLE;
                end
                ST_RX: if (bit_cnt_r == 4'h8) begin
                    state_r <= ST_ACK;
                end
                ST_TX: if (bit_cnt_r == 4'h8) begin
                    state_r <= ST_ACK;
                end
                ST_ACK: begin
                    bit_cnt_r <= 4'h0;
                    addr_ok_r <= 1'b0;
                    state_r <= reading_r ? ST_TX : ST_RX;
                end
                default: state_r <= state_r;
            endcase
        end
    end

    // Remember whether our own acknowledge is being driven this slot.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ack_drive_r <= 1'b0;
        end else begin
            ack_drive_r <= (state_r == ST_ACK) && (addr_ok_r || !reading_r);
        end
    end

    // SDA drive is updated after SCL falls and released at start or stop, so it is otherwise stable while high.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end else if (start_cond || stop_cond) begin
            sda_oe <= 1'b0;
        end else if (scl_fall) begin
            if (state_r == ST_ADDR && bit_cnt_r == 4'h8) begin
                sda_oe <= (shift_r[7:1] == TARGET_ADDR);
            end else if (state_r == ST_RX && bit_cnt_r == 4'h8) begin
                sda_oe <= 1'b1;
            end else if (state_r == ST_ACK && reading_r) begin
                sda_oe <= !read_byte[7];
            end else if (state_r == ST_TX && bit_cnt_r < 4'h8 && bit_cnt_r != 4'h0) begin
                sda_oe <= !read_byte[3'(LAST_DATA_BIT - bit_cnt_r)];
            end else begin
                sda_oe <= 1'b0;
            end
        end
    end

    // Register pointer and writes from received bytes.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_ptr_r <= 8'h00;
            ptr_loaded_r <= 1'b0;
            supply_sel_r <= SUPPLY_SEL_RESET;
            lockout_r <= LOCKOUT_RESET;
            cell_absent_r <= CELL_ABSENT_RESET;
            kick_r <= 1'b0;
        end else begin
            kick_r <= 1'b0;
            if (status.watchdog_expired) begin
                lockout_r <= 1'b0;
            end
            if (start_cond) begin
                ptr_loaded_r <= 1'b0;
            end else if (scl_fall && state_r == ST_RX && bit_cnt_r == 4'h8) begin
                if (!ptr_loaded_r) begin
                    reg_ptr_r <= shift_r;
                    ptr_loaded_r <= 1'b1;
                end else if (reg_ptr_r == REG_STATE_FAULT_CONTROL) begin
                    kick_r <= shift_r[KICK_BIT];
                    supply_sel_r <= shift_r[SUPPLY_SEL_BIT];
                end else if (reg_ptr_r == REG_SUPPLY_BATTERY_STATE) begin
                    lockout_r <= shift_r[LOCKOUT_BIT] && !status.watchdog_expired;
                    cell_absent_r <= shift_r[CELL_ABSENT_BIT];
                end
            end
        end
    end

    // A read of register 0 completes when its last bit has gone out.
    assign fault_read = scl_fall && state_r == ST_TX && bit_cnt_r == 4'h8
        && reg_ptr_r == REG_STATE_FAULT_CONTROL;

    // First fault latches; clears on read only once the fault has gone.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fault_r <= FAULT_NONE;
        end else if (fault_r == FAULT_NONE) begin
            if (status.fault_active) begin
                fault_r <= status.fault_code;
            end
        end else if (fault_read && !status.fault_active) begin
            fault_r <= FAULT_NONE;
        end
    end

    // Restart request on priority change with both supplies present, or on wrong active supply.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            restart_r <= 1'b0;
        end else begin
            restart_r <= on_wrong_supply
                || (both_supplies && scl_fall && state_r == ST_RX && bit_cnt_r == 4'h8
                && ptr_loaded_r && reg_ptr_r == REG_STATE_FAULT_CONTROL
                && shift_r[SUPPLY_SEL_BIT] != supply_sel_r);
        end
    end

    // Controls toward the charger, all registered.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            control <= '0;
        end else begin
            control.watchdog_kick <= kick_r;
            control.supply_sel <= supply_sel_r;
            control.bus_input_lockout <= lockout_r;
            control.cell_absent_operation <= cell_absent_r;
            control.gate_drive_rail <= bus_supply_present && !lockout_r;
            control.startup_restart <= restart_r;
            control.buck_off <= !cell_absent_r
                && status.cell_state == CELL_OVERVOLTAGE;
        end
    end

    property p_fault_holds;
        @(posedge mclk) disable iff (!rst_n)
        (fault_r != FAULT_NONE && !fault_read) |=> $stable(fault_r);
    endproperty
    a_fault_holds: assert property (p_fault_holds) else $error("fault code changed unread");

    property p_lock_release;
        @(posedge mclk) disable iff (!rst_n)
        status.watchdog_expired |=> !lockout_r;
    endproperty
    a_lock_release: assert property (p_lock_release) else $error("lockout kept");

    property p_gate_off;
        @(posedge mclk) disable iff (!rst_n)
        lockout_r |=> !control.gate_drive_rail;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("gate drive on in lockout");

    property p_sda_stable;
        @(posedge mclk) disable iff (!rst_n)
        (scl && !scl_fall && !start_cond && !stop_cond) |=> $stable(sda_oe);
    endproperty
    a_sda_stable: assert property (p_sda_stable) else $error("sda moved with scl high");

    property p_stop_idle;
        @(posedge mclk) disable iff (!rst_n)
        stop_cond |=> (state_r == ST_IDLE) && !sda_oe;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("no idle after stop");

    property p_start_addr;
        @(posedge mclk) disable iff (!rst_n)
        start_cond |=> state_r == ST_ADDR && bit_cnt_r == 4'h0;
    endproperty
    a_start_addr: assert property (p_start_addr) else $error("start missed");

    property p_unmapped;
        @(posedge mclk) disable iff (!rst_n)
        (reg_ptr_r > REG_SUPPLY_BATTERY_STATE) |-> read_byte == UNMAPPED_READ;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not ones");

    property p_buck;
        @(posedge mclk) disable iff (!rst_n)
        (!cell_absent_r && status.cell_state == CELL_OVERVOLTAGE) |=> control.buck_off;
    endproperty
    a_buck: assert property (p_buck) else $error("buck left on");

    // A foreign address leaves the target idle and the data line released.
    sequence s_foreign_addr;
        scl_fall && state_r == ST_ADDR && bit_cnt_r == 4'h8 && shift_r[7:1] != TARGET_ADDR;
    endsequence

    property p_foreign_quiet;
        @(posedge mclk) disable iff (!rst_n)
        s_foreign_addr |=> (state_r == ST_IDLE) && !sda_oe;
    endproperty
    a_foreign_quiet: assert property (p_foreign_quiet) else $error("foreign address acked");

    // While the clock is high in the address acknowledge slot the line is held low.
    sequence s_own_addr_high;
        state_r == ST_ACK && addr_ok_r && scl;
    endsequence

    property p_addr_ack_low;
        @(posedge mclk) disable iff (!rst_n)
        s_own_addr_high |-> sda_oe;
    endproperty
    a_addr_ack_low: assert property (p_addr_ack_low) else $error("address ack dropped");

    // A changed priority written with both supplies present requests a restart.
    sequence s_sel_flip;
        both_supplies && scl_fall && state_r == ST_RX && bit_cnt_r == 4'h8 && ptr_loaded_r
            && reg_ptr_r == REG_STATE_FAULT_CONTROL && shift_r[SUPPLY_SEL_BIT] != supply_sel_r;
    endsequence

    property p_sel_restart;
        @(posedge mclk) disable iff (!rst_n)
        s_sel_flip |=> ##1 control.startup_restart;
    endproperty
    a_sel_restart: assert property (p_sel_restart) else $error("no restart on swap");

    // The watchdog kick reaches the charger as a single-cycle pulse.
    property p_kick_pulse;
        @(posedge mclk) disable iff (!rst_n)
        control.watchdog_kick |=> !control.watchdog_kick;
    endproperty
    a_kick_pulse: assert property (p_kick_pulse) else $error("kick pulse too long");
endmodule

// *** core/chg_pkg.sv ***
package chg_pkg;
    // Bus address and register map.
    localparam logic [6:0] TARGET_ADDR = 7'h6B;
    localparam logic [7:0] REG_STATE_FAULT_CONTROL = 8'h00;
    localparam logic [7:0] REG_SUPPLY_BATTERY_STATE = 8'h01;
    localparam logic [7:0] UNMAPPED_READ = 8'hFF;

    // Field positions in register 0.
    localparam int KICK_BIT = 7;
    localparam int SUPPLY_SEL_BIT = 3;

    // Field positions in register 1.
    localparam int LOCKOUT_BIT = 3;
    localparam int CELL_ABSENT_BIT = 0;

    // Reset values of writable controls.
    localparam logic SUPPLY_SEL_RESET = 1'b0;
    localparam logic LOCKOUT_RESET = 1'b0;
    localparam logic CELL_ABSENT_RESET = 1'b0;

    // Fault codes.
    localparam logic [2:0] FAULT_NONE = 3'h0;
    localparam logic [2:0] FAULT_WATCHDOG = 3'h3;

    // Cell state codes.
    localparam logic [1:0] CELL_OVERVOLTAGE = 2'h1;

    // Index of the most significant bit of a unit, which is sent first.
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;

    // Live charger status gathered from the analog side.
    typedef struct packed {
        logic [2:0] charge_state;
        logic [2:0] fault_code;
        logic fault_active;
        logic [1:0] primary_input_state;
        logic [1:0] bus_input_state;
        logic [1:0] cell_state;
        logic watchdog_expired;
    } charger_status_type;

    // Controls driven back toward the charger.
    typedef struct packed {
        logic watchdog_kick;
        logic supply_sel;
        logic bus_input_lockout;
        logic cell_absent_operation;
        logic gate_drive_rail;
        logic startup_restart;
        logic buck_off;
    } charger_control_type;
endpackage

// *** core/pin_sync.sv ***
module pin_sync
    import chg_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // Three stages; a change is accepted once stages two and three agree.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
            level <= 1'b1;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level <= s3_r;
            end
        end
    end

    // Edges of the accepted level.
    assign rise = (s2_r == s3_r) && s3_r && !level;
    assign fall = (s2_r == s3_r) && !s3_r && level;
endmodule

// *** dv/i2c_host_model.sv ***
// Bus host that owns the clock line and an open-drain data driver.
module i2c_host_model (
    input wire logic mclk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_drv
);
    timeunit 1ns;
    timeprecision 100ps;

    // Both lines idle high, and the clock stands still outside frames.
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // One bit: data moves mid-low, clock is high three cycles, sampled before it falls.
    task automatic bit_xfer(input logic b, output logic r);
        tick(2);
        sda_drv <= b;
        tick(3);
        scl <= 1'b1;
        tick(3);
        r = sda_line;
        scl <= 1'b0;
    endtask

    // Data falls while the clock is high, then the clock drops.
    task automatic start_cond();
        tick(4);
        sda_drv <= 1'b0;
        tick(4);
        scl <= 1'b0;
    endtask

    // Data rises while the clock is high; also used to abandon a transfer.
    task automatic stop_cond();
        tick(2);
        sda_drv <= 1'b0;
        tick(3);
        scl <= 1'b1;
        tick(4);
        sda_drv <= 1'b1;
        tick(8);
    endtask

    // Eight bits, most significant first, then the receiver's acknowledge slot.
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(b[i], r);
        end
        bit_xfer(1'b1, ack);
    endtask

    // Reads a byte and answers it; a high acknowledge ends the read.
    task automatic recv_byte(input logic ack_bit, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, r);
            b[i] = r;
        end
        bit_xfer(ack_bit, r);
    endtask
endmodule

// *** dv/tb.sv ***
// Register-level test of the status target through the two-wire bus.
module tb;
    import chg_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic mclk;
    logic nrst;
    logic scl;
    logic host_sda;
    logic sda_line;
    logic sda_out;
    logic sda_oe;
    logic both_supplies;
    logic on_wrong_supply;
    logic bus_supply_present;
    charger_status_type status;
    charger_control_type control;
    int error_cnt;
    int n_tests;
    int kick_cnt;
    int restart_cnt;
    int restart_seen;
    logic [7:0] rdata;
    logic ack;

    // The wire is pulled high unless either party pulls it low.
    assign sda_line = host_sda & ~(sda_oe & ~sda_out);

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    charger_status_reg_target dut (.mclk(mclk), .nrst(nrst), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .status(status), .both_supplies(both_supplies),
        .on_wrong_supply(on_wrong_supply), .bus_supply_present(bus_supply_present),
        .control(control));

    i2c_host_model host (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_drv(host_sda));

    // Counts the cycles in which the kick and restart controls are high.
    always @(posedge mclk) begin
        if (control.watchdog_kick === 1'b1) kick_cnt++;
        if (control.startup_restart === 1'b1) restart_cnt++;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Sets the register pointer and writes one byte to it.
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        host.start_cond();
        host.send_byte({TARGET_ADDR, 1'b0}, ack);
        chk({7'h00, ack}, 8'h00);
        host.send_byte(ptr, ack);
        chk({7'h00, ack}, 8'h00);
        host.send_byte(d, ack);
        chk({7'h00, ack}, 8'h00);
        host.stop_cond();
    endtask

    // Sets the pointer, then reads the selected register in a second transfer.
    task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
        host.start_cond();
        host.send_byte({TARGET_ADDR, 1'b0}, ack);
        host.send_byte(ptr, ack);
        host.stop_cond();
        host.start_cond();
        host.send_byte({TARGET_ADDR, 1'b1}, ack);
        chk({7'h00, ack}, 8'h00);
        host.recv_byte(1'b1, d);
        host.stop_cond();
    endtask

    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (60000) @(posedge mclk);
        error_cnt++;
        conclude();
    end

    initial begin
        nrst = 1'b0;
        status = '0;
        both_supplies = 1'b1;
        on_wrong_supply = 1'b0;
        bus_supply_present = 1'b1;
        host.tick(16);
        nrst <= 1'b1;
        host.tick(10);
        status.primary_input_state <= 2'h2;
        status.bus_input_state <= 2'h1;
        status.cell_state <= 2'h2;
        rd(8'h01, rdata);
        chk(rdata, 8'h94);
        rd(8'h00, rdata);
        chk(rdata, 8'h00);
        wr(8'h00, 8'h88);
        chk(kick_cnt[7:0], 8'h01);
        chk(restart_cnt[7:0], 8'h01);
        chk({7'h00, control.supply_sel}, 8'h01);
        // Every state code shows live, with the kick bit reading zero.
        for (int s = 0; s < 8; s++) begin
            status.charge_state <= s[2:0];
            rd(8'h00, rdata);
            chk(rdata, {1'b0, s[2:0], 4'h8});
        end
        status.charge_state <= 3'h3;
        on_wrong_supply <= 1'b1;
        host.tick(20);
        on_wrong_supply <= 1'b0;
        chk({7'h00, restart_cnt > 1}, 8'h01);
        status.cell_state <= CELL_OVERVOLTAGE;
        host.tick(10);
        chk({7'h00, control.buck_off}, 8'h01);
        // A write to the unmapped register 2 comes first and changes nothing.
        wr(8'h02, 8'h0A);
        wr(8'h01, 8'h09);
        rd(8'h01, rdata);
        chk(rdata, 8'h9B);
        chk({7'h00, control.bus_input_lockout}, 8'h01);
        chk({7'h00, control.gate_drive_rail}, 8'h00);
        chk({7'h00, control.cell_absent_operation}, 8'h01);
        chk({7'h00, control.buck_off}, 8'h00);
        status.watchdog_expired <= 1'b1;
        host.tick(10);
        status.watchdog_expired <= 1'b0;
        rd(8'h01, rdata);
        chk(rdata, 8'h93);
        chk({7'h00, control.bus_input_lockout}, 8'h00);
        chk({7'h00, control.gate_drive_rail}, 8'h01);
        // Without the bus supply the gate drive stays off.
        bus_supply_present <= 1'b0;
        host.tick(4);
        chk({7'h00, control.gate_drive_rail}, 8'h00);
        bus_supply_present <= 1'b1;
        // The first fault stays latched and clears only on a read once it is gone.
        status.fault_active <= 1'b1;
        status.fault_code <= 3'h1;
        host.tick(10);
        status.fault_code <= 3'h2;
        rd(8'h00, rdata);
        chk(rdata, 8'h39);
        rd(8'h00, rdata);
        chk(rdata, 8'h39);
        status.fault_active <= 1'b0;
        status.fault_code <= FAULT_NONE;
        rd(8'h00, rdata);
        chk(rdata, 8'h39);
        rd(8'h00, rdata);
        chk(rdata, 8'h38);
        rd(8'h05, rdata);
        chk(rdata, UNMAPPED_READ);
        rd(8'h02, rdata);
        chk(rdata, 8'hFF);
        host.start_cond();
        host.send_byte({7'h6A, 1'b0}, ack);
        chk({7'h00, ack}, 8'h01);
        host.stop_cond();
        host.start_cond();
        host.send_byte({TARGET_ADDR, 1'b0}, ack);
        host.stop_cond();
        rd(8'h00, rdata);
        chk(rdata, 8'h38);
        // With one supply a priority change needs no restart.
        restart_seen = restart_cnt;
        both_supplies <= 1'b0;
        wr(8'h00, 8'h00);
        chk(8'(restart_cnt - restart_seen), 8'h00);
        chk({7'h00, control.supply_sel}, 8'h00);
        rd(8'h00, rdata);
        chk(rdata, 8'h30);
        conclude();
    end
endmodule
